// *** rtl/ebt_timer.sv ***
// Purpose: eight-bit timer with two compare channels behind an APB slave
// Assumes: 40 MHz clk_sys, synchronous active-high reset
// Notes: osc source taken as pin edges sampled by clk_sys
// Functional notes
// R1: counter and compare registers are eight bits
// R2: flags in one register, mask gates each
// R3: clock select zero stops the counter
// R4: io clock default, oscillator when async set; code counts pin edges only on io prescaler tap hits
// R5: per tick clear, increment or decrement
// R6: software counter write beats count
// R7: three-bit waveform mode split over a/b
// R8: bottom at 00, max at FF
// R9: top is FF or compare a
// R10: overflow flag per mode, raises request
// R11: continuous eight-bit equality per channel
// R12: compare flag set tick after match
// R13: request when flag and mask; service clears
// R14: write one clears flag, zero keeps
// R15: double buffer only in pwm modes
// R16: buffer copied only at top or bottom
// R17: software reaches buffer or active register
// R18: force strobe acts like match, no flag
// R19: counter write blocks next tick match
// R20: output from match, mode and output bits
// R21: output state kept across mode change
// R22: output mode bits take effect at once
// R23: software sets output before pin direction
// R24: software avoids writes that lose matches
// R25: normal mode wraps, overflow when zero
// R26: output mode zero leaves state alone
// R27: timer tick is an io clock enable
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "ebt_consts.svh"
module ebt_timer (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic osc_pin_in,
  input wire logic [2:0] irq_service,
  output logic [2:0] irq_request,
  output logic compare_output_a,
  output logic compare_output_b
);
  logic [7:0] control_reg_a;
  logic [7:0] control_reg_b;
  logic [7:0] counter_value_reg; // R1
  logic [7:0] cmp_act_r [2];
  logic [7:0] cmp_buf_r [2];
  logic [2:0] interrupt_mask_reg;
  logic [2:0] interrupt_flag_reg;
  logic async_clock_select;
  logic oc_r [2];
  logic block_r;
  logic tick_d_r;
  ebt_pkg::ebt_dir_type dir_r;
  logic timer_tick;
  logic [2:0] waveform_mode_field;
  logic [2:0] clock_select_field;
  logic pwm_mode;
  logic phase_mode;
  logic top_is_a;
  logic [7:0] top_val;
  logic at_top;
  logic at_bottom;
  logic at_max;
  logic wr_en;
  logic rd_en;
  logic hit_ca;
  logic hit_cb;
  logic hit_cnt;
  logic hit_ma;
  logic hit_mb;
  logic hit_mask;
  logic hit_flag;
  logic hit_async;
  logic hit_map;
  logic [7:0] wbyte;
  logic [7:0] cnt_nxt;
  logic ovf_evt;
  logic upd_evt;
  logic [1:0] match_raw;
  logic [1:0] match_ok;
  logic [1:0] force_hit;
  logic [31:0] rdata_nxt;
  logic [7:0] cmp_vis [2];
  logic [2:0] set_evt;

  assign waveform_mode_field = {control_reg_b[`EBT_CB_WGM2],
    control_reg_a[`EBT_CA_WGM_HI:`EBT_CA_WGM_LO]}; // R7
  assign clock_select_field = control_reg_b[`EBT_CB_CS_HI:`EBT_CB_CS_LO];
  assign pwm_mode = waveform_mode_field[0]; // R15
  assign phase_mode = waveform_mode_field[0] & ~waveform_mode_field[1];
  assign top_is_a = (waveform_mode_field == ebt_pkg::EBT_WGM_CTC) |
    waveform_mode_field[2];
  assign top_val = top_is_a ? cmp_act_r[0] : `EBT_MAX; // R9
  assign at_top = (counter_value_reg == top_val);
  assign at_bottom = (counter_value_reg == `EBT_BOTTOM); // R8
  assign at_max = (counter_value_reg == `EBT_MAX); // R8

  ebt_tick_gen u_tick (
    .clk_sys(clk_sys),
    .reset(reset),
    .clock_select_field(clock_select_field),
    .async_clock_select(async_clock_select),
    .osc_pin_in(osc_pin_in),
    .timer_tick(timer_tick)
  ); // R3 R4 R27

  // apb decode: zero wait, error on unmapped address
  assign hit_ca = (paddr == `EBT_OFS_CTRL_A);
  assign hit_cb = (paddr == `EBT_OFS_CTRL_B);
  assign hit_cnt = (paddr == `EBT_OFS_COUNT);
  assign hit_ma = (paddr == `EBT_OFS_CMP_A);
  assign hit_mb = (paddr == `EBT_OFS_CMP_B);
  assign hit_mask = (paddr == `EBT_OFS_IMASK);
  assign hit_flag = (paddr == `EBT_OFS_IFLAG);
  assign hit_async = (paddr == `EBT_OFS_ASYNC);
  assign hit_map = hit_ca | hit_cb | hit_cnt | hit_ma | hit_mb | hit_mask |
    hit_flag | hit_async;
  assign wr_en = psel & penable & pready & pwrite & hit_map;
  assign rd_en = psel & ~penable & ~pwrite;
  assign wbyte = pwdata[7:0];
  assign cmp_vis[0] = pwm_mode ? cmp_buf_r[0] : cmp_act_r[0]; // R17
  assign cmp_vis[1] = pwm_mode ? cmp_buf_r[1] : cmp_act_r[1]; // R17
  assign rdata_nxt = hit_ca ? {24'h00_0000, control_reg_a} :
    hit_cb ? {24'h00_0000, 2'b00, control_reg_b[5:0]} :
    hit_cnt ? {24'h00_0000, counter_value_reg} :
    hit_ma ? {24'h00_0000, cmp_vis[0]} :
    hit_mb ? {24'h00_0000, cmp_vis[1]} :
    hit_mask ? {29'h0000_0000, interrupt_mask_reg} :
    hit_flag ? {29'h0000_0000, interrupt_flag_reg} :
    hit_async ? {26'h000_0000, async_clock_select, 5'h00} :
    32'h0000_0000;

  always_ff @(posedge clk_sys) begin
    if (reset) pready <= 1'b0;
    else pready <= psel & ~penable;
  end
  always_ff @(posedge clk_sys) begin
    if (reset) pslverr <= 1'b0;
    else pslverr <= psel & ~penable & ~hit_map;
  end
  always_ff @(posedge clk_sys) begin
    if (reset) prdata <= 32'h0000_0000;
    else if (rd_en) prdata <= rdata_nxt;
  end

  // control registers; force strobes read zero, act on write only
  always_ff @(posedge clk_sys) begin
    if (reset) control_reg_a <= `EBT_RESET_BYTE;
    else if (wr_en & hit_ca) control_reg_a <= wbyte; // R22
  end
  always_ff @(posedge clk_sys) begin
    if (reset) control_reg_b <= `EBT_RESET_BYTE;
    else if (wr_en & hit_cb) control_reg_b <= {2'b00, wbyte[5:0]};
  end
  always_ff @(posedge clk_sys) begin
    if (reset) async_clock_select <= 1'b0;
    else if (wr_en & hit_async) async_clock_select <= wbyte[`EBT_ASYNC_SEL]; // R4
  end
  always_ff @(posedge clk_sys) begin
    if (reset) interrupt_mask_reg <= 3'h0;
    else if (wr_en & hit_mask) interrupt_mask_reg <= wbyte[2:0]; // R2
  end

  // counter sequence
  always_comb begin
    cnt_nxt = counter_value_reg;
    if (phase_mode) begin
      if (dir_r == ebt_pkg::EBT_DIR_UP) cnt_nxt = at_top ? counter_value_reg - 8'h01 :
        counter_value_reg + 8'h01;
      else cnt_nxt = at_bottom ? counter_value_reg + 8'h01 : counter_value_reg - 8'h01;
    end else if (top_is_a & at_top) begin
      cnt_nxt = `EBT_BOTTOM;
    end else begin
      cnt_nxt = counter_value_reg + 8'h01; // R25
    end
  end // R5
  always_ff @(posedge clk_sys) begin
    if (reset) counter_value_reg <= `EBT_RESET_BYTE;
    else if (wr_en & hit_cnt) counter_value_reg <= wbyte; // R6
    else if (timer_tick) counter_value_reg <= cnt_nxt; // R5
  end
  always_ff @(posedge clk_sys) begin
    if (reset) dir_r <= ebt_pkg::EBT_DIR_UP;
    else if (~phase_mode) dir_r <= ebt_pkg::EBT_DIR_UP;
    else if (timer_tick & at_top) dir_r <= ebt_pkg::EBT_DIR_DOWN;
    else if (timer_tick & at_bottom) dir_r <= ebt_pkg::EBT_DIR_UP;
  end

  // overflow: wrap to zero in single slope, bottom in dual slope
  assign ovf_evt = timer_tick & (phase_mode ? at_bottom :
    (top_is_a & ~pwm_mode ? at_max : at_top)); // R10 R25
  // buffered values land at top (fast) or top of dual slope
  assign upd_evt = timer_tick & (phase_mode ? at_top : at_top); // R16

  // matches, blocked for one tick after a counter write
  always_ff @(posedge clk_sys) begin
    if (reset) block_r <= 1'b0;
    else if (wr_en & hit_cnt) block_r <= 1'b1;
    else if (timer_tick) block_r <= 1'b0;
  end // R19
  always_ff @(posedge clk_sys) begin
    if (reset) tick_d_r <= 1'b0;
    else tick_d_r <= timer_tick;
  end
  assign force_hit[0] = wr_en & hit_cb & wbyte[`EBT_CB_FOCA] & ~pwm_mode; // R18
  assign force_hit[1] = wr_en & hit_cb & wbyte[`EBT_CB_FOCB] & ~pwm_mode; // R18

  generate
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      logic [1:0] com;
      logic act;
      assign com = (ch == 0) ? control_reg_a[`EBT_CA_COMA_HI:`EBT_CA_COMA_LO] :
        control_reg_a[`EBT_CA_COMB_HI:`EBT_CA_COMB_LO];
      assign match_raw[ch] = (counter_value_reg == cmp_act_r[ch]); // R11
      assign match_ok[ch] = timer_tick & match_raw[ch] & ~block_r; // R19
      assign act = match_ok[ch] | force_hit[ch];
      always_ff @(posedge clk_sys) begin
        if (reset) cmp_act_r[ch] <= `EBT_RESET_BYTE;
        else if (~pwm_mode & wr_en & (ch == 0 ? hit_ma : hit_mb)) cmp_act_r[ch] <= wbyte; // R17
        else if (pwm_mode & upd_evt) cmp_act_r[ch] <= cmp_buf_r[ch]; // R16
      end
      always_ff @(posedge clk_sys) begin
        if (reset) cmp_buf_r[ch] <= `EBT_RESET_BYTE;
        else if (wr_en & (ch == 0 ? hit_ma : hit_mb)) cmp_buf_r[ch] <= wbyte; // R15
      end
      // state not touched by mode change; only match, force or pwm bottom
      always_ff @(posedge clk_sys) begin
        if (reset) oc_r[ch] <= 1'b0;
        else if (com == 2'b00) oc_r[ch] <= oc_r[ch]; // R26 R21
        else if (~pwm_mode & act) begin
          oc_r[ch] <= (com == 2'b01) ? ~oc_r[ch] : (com == 2'b11); // R20 R22
        end else if (pwm_mode & com[1] & match_ok[ch]) begin
          oc_r[ch] <= phase_mode ? ((dir_r == ebt_pkg::EBT_DIR_UP) ~^ com[0]) : com[0];
        end else if (pwm_mode & ~phase_mode & com[1] & timer_tick & at_max & ~top_is_a) begin
          oc_r[ch] <= ~com[0];
        end else if (pwm_mode & ~phase_mode & com[1] & timer_tick & top_is_a & at_top) begin
          oc_r[ch] <= ~com[0];
        end
      end
    end
  endgenerate

  // flags: hardware set wins over write-one and service clears
  logic [2:0] flag_clr;
  logic [2:0] flag_nxt;
  assign set_evt = {match_ok[1], match_ok[0], ovf_evt}; // R12
  assign flag_clr = (wr_en & hit_flag) ? wbyte[2:0] : 3'h0; // R14
  assign flag_nxt = set_evt | (interrupt_flag_reg & ~flag_clr & ~irq_service); // R13
  always_ff @(posedge clk_sys) begin
    if (reset) interrupt_flag_reg <= 3'h0;
    else interrupt_flag_reg <= flag_nxt; // R14 R13
  end
  // request follows the flag, gated by its own mask bit
  always_ff @(posedge clk_sys) begin
    if (reset) irq_request <= 3'h0;
    else irq_request <= flag_nxt & interrupt_mask_reg; // R2 R13
  end
  always_ff @(posedge clk_sys) begin
    if (reset) compare_output_a <= 1'b0;
    else compare_output_a <= oc_r[0];
  end
  always_ff @(posedge clk_sys) begin
    if (reset) compare_output_b <= 1'b0;
    else compare_output_b <= oc_r[1];
  end

  // checks
  chk_flag_after_match: assert property (@(posedge clk_sys) disable iff (reset)
    match_ok[0] |=> interrupt_flag_reg[`EBT_FL_CMPA]) else $error("flag a missed"); // R12
  chk_stop_no_tick: assert property (@(posedge clk_sys) disable iff (reset)
    (clock_select_field == 3'h0) ##1 (clock_select_field == 3'h0) |-> !timer_tick)
    else $error("tick while stopped"); // R3
  chk_write_wins: assert property (@(posedge clk_sys) disable iff (reset)
    (wr_en && hit_cnt) |=> counter_value_reg == $past(wbyte)) else $error("count write lost"); // R6
  chk_block_match: assert property (@(posedge clk_sys) disable iff (reset)
    (wr_en && hit_cnt) |=> !match_ok[0] && !match_ok[1]) else $error("match not blocked"); // R19
  chk_wrap_ovf: assert property (@(posedge clk_sys) disable iff (reset)
    (waveform_mode_field == 3'h0 && timer_tick && at_max && !(wr_en && hit_cnt)) |=>
    counter_value_reg == 8'h00 && interrupt_flag_reg[`EBT_FL_OVF]) else $error("wrap bad"); // R25
  chk_force_noflag: assert property (@(posedge clk_sys) disable iff (reset)
    (force_hit[0] && !match_ok[0] && !interrupt_flag_reg[`EBT_FL_CMPA]) |=>
    !interrupt_flag_reg[`EBT_FL_CMPA]) else $error("force set flag"); // R18
  chk_nobuf_direct: assert property (@(posedge clk_sys) disable iff (reset)
    (!pwm_mode && wr_en && hit_ma) |=> cmp_act_r[0] == $past(wbyte)) else $error("direct write"); // R17
  chk_buf_hold: assert property (@(posedge clk_sys) disable iff (reset)
    (pwm_mode && !upd_evt) |=> $stable(cmp_act_r[0])) else $error("buffer leaked"); // R16
  chk_wr1_clear: assert property (@(posedge clk_sys) disable iff (reset)
    (wr_en && hit_flag && wbyte[1] && !match_ok[0]) |=> !interrupt_flag_reg[1])
    else $error("flag not cleared"); // R14
  chk_com_zero: assert property (@(posedge clk_sys) disable iff (reset)
    (control_reg_a[7:6] == 2'b00) |=> $stable(oc_r[0])) else $error("com zero acted"); // R26
  chk_mask_gate: assert property (@(posedge clk_sys) disable iff (reset) // R2
    (irq_request & ~$past(interrupt_mask_reg)) == 3'h0) else $error("masked request seen");
endmodule

// *** rtl/ebt_consts.svh ***
// Purpose: offsets, field positions, reset values and timing counts of the timer
// Assumes: 32-bit APB data, one register per aligned word
// Notes: included by bare name
`ifndef EBT_CONSTS_SVH
`define EBT_CONSTS_SVH
`define EBT_OFS_CTRL_A 12'h000
`define EBT_OFS_CTRL_B 12'h004
`define EBT_OFS_COUNT 12'h008
`define EBT_OFS_CMP_A 12'h00C
`define EBT_OFS_CMP_B 12'h010
`define EBT_OFS_IMASK 12'h014
`define EBT_OFS_IFLAG 12'h018
`define EBT_OFS_ASYNC 12'h01C
`define EBT_OFS_SVC 12'h020
// control a: [7:6] mode a, [5:4] mode b, [1:0] waveform bits 1..0
`define EBT_CA_COMA_HI 7
`define EBT_CA_COMA_LO 6
`define EBT_CA_COMB_HI 5
`define EBT_CA_COMB_LO 4
`define EBT_CA_WGM_HI 1
`define EBT_CA_WGM_LO 0
// control b: [7] force a, [6] force b, [3] waveform bit 2, [2:0] clock select
`define EBT_CB_FOCA 7
`define EBT_CB_FOCB 6
`define EBT_CB_WGM2 3
`define EBT_CB_CS_HI 2
`define EBT_CB_CS_LO 0
// flag / mask bit positions
`define EBT_FL_OVF 0
`define EBT_FL_CMPA 1
`define EBT_FL_CMPB 2
`define EBT_ASYNC_SEL 5
`define EBT_RESET_BYTE 8'h00
`define EBT_BOTTOM 8'h00
`define EBT_MAX 8'hFF
// prescaler tap divisors
`define EBT_DIV_8 10'd7
`define EBT_DIV_32 10'd31
`define EBT_DIV_64 10'd63
`define EBT_DIV_128 10'd127
`define EBT_DIV_256 10'd255
`define EBT_DIV_1024 10'd1023
`endif

// *** rtl/ebt_pkg.sv ***
// Purpose: types of the eight-bit timer
// Assumes: constants come from ebt_consts.svh
// Notes: none
package ebt_pkg;
  typedef enum logic [2:0] {
    EBT_WGM_NORMAL = 3'h0,
    EBT_WGM_PC_FF = 3'h1,
    EBT_WGM_CTC = 3'h2,
    EBT_WGM_FAST_FF = 3'h3,
    EBT_WGM_RSV4 = 3'h4,
    EBT_WGM_PC_OCA = 3'h5,
    EBT_WGM_RSV6 = 3'h6,
    EBT_WGM_FAST_OCA = 3'h7
  } ebt_wgm_type;
  typedef struct packed {
    logic [1:0] com;
    logic force_strobe;
    logic match;
  } ebt_chan_type;
  typedef enum logic [1:0] {
    EBT_DIR_UP = 2'b01,
    EBT_DIR_DOWN = 2'b10
  } ebt_dir_type;
endpackage

// *** rtl/ebt_tick_gen.sv ***
// Purpose: timer tick enable from the io clock prescaler or the oscillator pin
// Assumes: osc_pin_in synchronous to clk_sys; one clock only
// Notes: tick is a one-cycle enable, never a clock net
`timescale 1ns/10ps
`include "ebt_consts.svh"
module ebt_tick_gen (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [2:0] clock_select_field,
  input wire logic async_clock_select,
  input wire logic osc_pin_in,
  output logic timer_tick
);
  logic [9:0] pre_r;
  logic osc_d_r;
  logic src_tick;
  logic tap_hit;
  logic osc_edge;
  // free running prescaler, like the shared one, so first tick may be early
  always_ff @(posedge clk_sys) begin
    if (reset) pre_r <= 10'h000;
    else pre_r <= pre_r + 10'h001;
  end
  always_ff @(posedge clk_sys) begin
    if (reset) osc_d_r <= 1'b0;
    else osc_d_r <= osc_pin_in;
  end
  assign osc_edge = osc_pin_in & ~osc_d_r;
  assign tap_hit = (clock_select_field == 3'h1) ? 1'b1 :
    (clock_select_field == 3'h2) ? ((pre_r & `EBT_DIV_8) == 10'h000) :
    (clock_select_field == 3'h3) ? ((pre_r & `EBT_DIV_32) == 10'h000) :
    (clock_select_field == 3'h4) ? ((pre_r & `EBT_DIV_64) == 10'h000) :
    (clock_select_field == 3'h5) ? ((pre_r & `EBT_DIV_128) == 10'h000) :
    (clock_select_field == 3'h6) ? ((pre_r & `EBT_DIV_256) == 10'h000) :
    ((pre_r & `EBT_DIV_1024) == 10'h000);
  // oscillator source: a rising pin edge gives a tick only when the io prescaler tap also hits
  assign src_tick = async_clock_select ? (osc_edge & tap_hit) : tap_hit;
  always_ff @(posedge clk_sys) begin
    if (reset) timer_tick <= 1'b0;
    else timer_tick <= (clock_select_field != 3'h0) & src_tick;
  end
endmodule

// *** sim/ebt_core_model.sv ***
// Purpose: core side of the timer, apb master and interrupt service strobes
// Assumes: slave raises pready in the access phase
// Notes: bus tasks are called from the bench
`timescale 1ns/10ps
module ebt_core_model (
  input wire logic clk_sys,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic [2:0] irq_service
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    irq_service = 3'h0;
  end
  // request held until pready is seen at an edge, no cycle count assumed
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic err);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // stale data must not look valid after release
    pwdata <= ~d;
  endtask
  // one-cycle strobe as when the vector runs
  task automatic service(input int idx);
    @(posedge clk_sys);
    irq_service <= 3'(1 << idx);
    @(posedge clk_sys);
    irq_service <= 3'h0;
  endtask
endmodule

// *** sim/eight_bit_timer_compare_unit_tb.sv ***
// Purpose: self-checking bench of the eight-bit timer
// Assumes: oscillator pin edges give exact tick counts when async is set and clock select is 1
// Notes: random starts from a fixed lfsr seed
`timescale 1ns/10ps
`include "ebt_consts.svh"
module eight_bit_timer_compare_unit_tb;
  logic clk_sys, reset, osc_pin_in, psel, penable, pwrite, pready, pslverr;
  logic compare_output_a, compare_output_b;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  logic [2:0] irq_service, irq_request;
  int err_total, samples_checked, cyc;
  ebt_timer ebt_timer_i (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .osc_pin_in(osc_pin_in), .irq_service(irq_service),
    .irq_request(irq_request), .compare_output_a(compare_output_a),
    .compare_output_b(compare_output_b));
  ebt_core_model ebt_core_model_i (.clk_sys(clk_sys), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_service(irq_service));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      finish_test();
    end
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    ebt_core_model_i.bus(1'b1, a, d, q, e);
    chk("write error", 32'h0000_0000, {31'h0, e});
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string name);
    logic [31:0] q;
    logic e;
    ebt_core_model_i.bus(1'b0, a, 32'h0000_0000, q, e);
    chk(name, exp, q);
  endtask
  // pin stays high for two system cycles and low for three so no edge is lost to sampling
  task automatic edges(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      osc_pin_in <= 1'b1;
      repeat (2) @(posedge clk_sys);
      osc_pin_in <= 1'b0;
      repeat (2) @(posedge clk_sys);
    end
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic run(input int n);
    wr(`EBT_OFS_CTRL_B, 32'h0000_0001);
    edges(n);
    wr(`EBT_OFS_CTRL_B, 32'h0000_0000);
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] exp_up(input logic [7:0] s, input int n);
    return {24'h0, 8'(int'(s) + n)};
  endfunction
  function automatic logic [31:0] exp_ctc(input int n, input logic [7:0] c);
    return {24'h0, 8'(n % (int'(c) + 1))};
  endfunction
  initial begin
    logic [7:0] s, c;
    logic [31:0] q;
    logic e;
    int n;
    reset = 1'b1;
    osc_pin_in = 1'b0;
    err_total = 0;
    samples_checked = 0;
    cyc = 0;
    seed = 32'h8679_261c;
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    for (int i = 0; i < 8; i++) rd(12'(4 * i), 32'h0000_0000, "reset value");
    ebt_core_model_i.bus(1'b0, 12'h024, 32'h0000_0000, q, e);
    chk("unmapped read error", 32'h0000_0001, {31'h0, e});
    chk("unmapped read data", 32'h0000_0000, q);
    ebt_core_model_i.bus(1'b1, 12'h024, 32'hffff_ffff, q, e);
    chk("unmapped write error", 32'h0000_0001, {31'h0, e});
    wr(`EBT_OFS_COUNT, 32'hffff_ffab);
    rd(`EBT_OFS_COUNT, 32'h0000_00ab, "counter width");
    repeat (20) @(posedge clk_sys);
    rd(`EBT_OFS_COUNT, 32'h0000_00ab, "stopped counter");
    wr(`EBT_OFS_IMASK, 32'h0000_0005);
    rd(`EBT_OFS_IMASK, 32'h0000_0005, "mask");
    wr(`EBT_OFS_CTRL_B, 32'h0000_0001);
    repeat (30) @(posedge clk_sys);
    wr(`EBT_OFS_CTRL_B, 32'h0000_0000);
    ebt_core_model_i.bus(1'b0, `EBT_OFS_COUNT, 32'h0000_0000, q, e);
    chk("io clock run", 32'h0000_0001, {31'h0, q[7:0] != 8'hab});
    wr(`EBT_OFS_ASYNC, 32'h0000_0020);
    edges(3);
    rd(`EBT_OFS_COUNT, {24'h0, q[7:0]}, "no select no tick");
    wr(`EBT_OFS_CMP_B, 32'h0000_0080);
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      s = 8'hf0 | 8'(seed[3:0]);
      n = 1 + int'(seed[8:4]) % 20;
      c = 8'h02 + 8'(seed[11:9]);
      wr(`EBT_OFS_IFLAG, 32'h0000_0007);
      wr(`EBT_OFS_COUNT, {24'h0, s});
      run(n);
      rd(`EBT_OFS_COUNT, exp_up(s, n), "normal count");
      chk("overflow flag", {31'h0, int'(s) + n > 255}, {31'h0, irq_request[0]});
      wr(`EBT_OFS_CTRL_A, 32'h0000_0002);
      wr(`EBT_OFS_CMP_A, {24'h0, c});
      wr(`EBT_OFS_COUNT, 32'h0000_0000);
      run(n);
      rd(`EBT_OFS_COUNT, exp_ctc(n, c), "ctc count");
      wr(`EBT_OFS_CTRL_A, 32'h0000_0000);
    end
    wr(`EBT_OFS_CTRL_A, 32'h0000_0001);
    wr(`EBT_OFS_COUNT, 32'h0000_00fd);
    run(5);
    rd(`EBT_OFS_COUNT, 32'h0000_00fc, "dual slope");
    wr(`EBT_OFS_CTRL_A, 32'h0000_0000);
    wr(`EBT_OFS_CMP_A, 32'h0000_0033);
    wr(`EBT_OFS_COUNT, 32'h0000_0033);
    wr(`EBT_OFS_IFLAG, 32'h0000_0007);
    run(3);
    rd(`EBT_OFS_IFLAG, 32'h0000_0000, "blocked match");
    wr(`EBT_OFS_CMP_A, 32'h0000_0037);
    run(2);
    rd(`EBT_OFS_IFLAG, 32'h0000_0002, "compare flag");
    chk("masked request", 32'h0000_0000, {29'h0, irq_request});
    ebt_core_model_i.service(1);
    rd(`EBT_OFS_IFLAG, 32'h0000_0000, "serviced flag");
    wr(`EBT_OFS_COUNT, 32'h0000_00ff);
    run(1);
    wr(`EBT_OFS_IFLAG, 32'h0000_0000);
    rd(`EBT_OFS_IFLAG, 32'h0000_0001, "flag kept");
    wr(`EBT_OFS_IFLAG, 32'h0000_0001);
    rd(`EBT_OFS_IFLAG, 32'h0000_0000, "flag cleared");
    wr(`EBT_OFS_CTRL_A, 32'h0000_0003);
    wr(`EBT_OFS_CMP_B, 32'h0000_0012);
    rd(`EBT_OFS_CMP_B, 32'h0000_0012, "buffer read");
    wr(`EBT_OFS_COUNT, 32'h0000_0010);
    run(4);
    rd(`EBT_OFS_IFLAG, 32'h0000_0000, "buffered compare");
    wr(`EBT_OFS_CTRL_A, 32'h0000_0000);
    wr(`EBT_OFS_CTRL_B, 32'h0000_0080);
    repeat (4) @(posedge clk_sys);
    chk("output mode zero", 32'h0000_0000, {31'h0, compare_output_a});
    wr(`EBT_OFS_CTRL_A, 32'h0000_0040);
    wr(`EBT_OFS_CTRL_B, 32'h0000_0080);
    repeat (4) @(posedge clk_sys);
    chk("forced toggle", 32'h0000_0001, {31'h0, compare_output_a});
    chk("other channel", 32'h0000_0000, {31'h0, compare_output_b});
    rd(`EBT_OFS_IFLAG, 32'h0000_0000, "force no flag");
    wr(`EBT_OFS_CTRL_A, 32'h0000_0043);
    wr(`EBT_OFS_CTRL_A, 32'h0000_0040);
    repeat (4) @(posedge clk_sys);
    chk("state across modes", 32'h0000_0001, {31'h0, compare_output_a});
    finish_test();
  end
endmodule
